/* File: hdl/rmse_pkg.sv */
// ****************************************************************************
// Shared constants and types of the rms measurement engine
// ****************************************************************************
package rmse_pkg;

  // ****************************************************************************
  // Channel map: results, offsets and samples share one index
  // ****************************************************************************
  localparam int NCH          = 18;
  localparam int SW           = 26;   // Working sample width after sums
  localparam int SQW          = 52;   // Square width
  localparam int FILT_SHIFT   = 10;   // One-pole low-pass, tau of 1024 cycles
  localparam int FW           = SQW + FILT_SHIFT;

  localparam logic [4:0] CH_CUR_A   = 5'h00;
  localparam logic [4:0] CH_CUR_B   = 5'h01;
  localparam logic [4:0] CH_CUR_C   = 5'h02;
  localparam logic [4:0] CH_CUR_N   = 5'h03;
  localparam logic [4:0] CH_VOLT_A  = 5'h04;
  localparam logic [4:0] CH_VOLT_B  = 5'h05;
  localparam logic [4:0] CH_VOLT_C  = 5'h06;
  localparam logic [4:0] CH_FVOLT_A = 5'h0f;
  localparam logic [4:0] CH_FVOLT_B = 5'h10;
  localparam logic [4:0] CH_FVOLT_C = 5'h11;
  localparam logic [4:0] CH_LAST    = 5'h11;

  // ****************************************************************************
  // Register indices on the register port
  // ****************************************************************************
  localparam logic [7:0] ADDR_RES_BASE  = 8'h00;
  localparam logic [7:0] ADDR_OFFS_BASE = 8'h20;
  localparam logic [7:0] ADDR_CONFIG    = 8'h40;
  localparam logic [7:0] ADDR_ACCUMULATION_MODE_REGISTER   = 8'h41;
  localparam logic [7:0] ADDR_RUN       = 8'h42;

  // ****************************************************************************
  // Field positions, codes and reset values
  // ****************************************************************************
  localparam int          NSEL_BIT       = 14;
  localparam int          WIRE_LO        = 4;
  localparam int          WIRE_HI        = 5;
  localparam logic [1:0]  WIRE_DELTA     = 2'h1;
  localparam logic [15:0] RUN_START      = 16'h0001;
  localparam logic        NSEL_RST       = 1'b0;
  localparam logic [1:0]  WIRE_RST       = 2'h0;
  localparam logic        RUN_RST        = 1'b0;
  localparam logic [23:0] RES_SAT        = 24'h7fffff;

  // ****************************************************************************
  // Timing
  // ****************************************************************************
  localparam int          CLK_HZ          = 200_000_000;
  localparam int          CYCLE_RATE_HZ   = 8_000;
  localparam logic [14:0] RMSE_CYCLE_CLKS = 15'(CLK_HZ / CYCLE_RATE_HZ);
  localparam int          SETTLE_MS       = 580;
  localparam int          SETTLE_CYCLES   = SETTLE_MS * CYCLE_RATE_HZ / 1000;

  // ****************************************************************************
  // Types
  // ****************************************************************************
  // Declared last-first so that cur_a lands at index 0 of the flat view
  typedef struct packed {
    logic signed [23:0] fvolt_c, fvolt_b, fvolt_a, fcur_c, fcur_b, fcur_a;
    logic signed [23:0] volt2_n, volt2_c, volt2_b, volt2_a;
    logic signed [23:0] volt_n, volt_c, volt_b, volt_a;
    logic signed [23:0] cur_n, cur_c, cur_b, cur_a;
  } rmse_samples_s;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rmse_reg_req_s;

  typedef struct packed {
    logic        rvalid;
    logic        err;
    logic [31:0] rdata;
  } rmse_reg_rsp_s;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FILT   = 4'b0010,
    ST_ROOT   = 4'b0100,
    ST_COMMIT = 4'b1000
  } rmse_state_e;

  typedef struct packed {
    rmse_state_e                 fsm;
    logic [14:0]                 timer;
    logic                        run;
    logic                        nsel;
    logic [1:0]                  wiring;
    logic [4:0]                  chan;
    logic [4:0]                  bitn;
    logic [SQW-1:0]              rad;
    logic [SW-1:0]               root;
    logic [NCH-1:0][SW-1:0]      smp;
    logic [NCH-1:0][FW-1:0]      filt;
    logic [NCH-1:0][23:0]        offs;
    logic [NCH-1:0][23:0]        stage;
    logic [NCH-1:0][23:0]        res;
    rmse_reg_rsp_s               rsp;
    logic                        busy;
    logic                        done;
    logic                        delta;
  } rmse_state_s;

endpackage

/* File: hdl/rmse_engine.sv */
// Functional notes
// - Square, low-pass filter, then square root
// - Total result carries every harmonic's energy
// - Each result is signed 24-bit, own register
// - Six fundamental-only results, separate registers
// - All results refreshed together at 8 kHz
// - Config bit 14 picks neutral or phase sum
// - Delta: neutral result unchanged, still set by config bit 14
// - Full-scale sine gives rms code 3,761,808
// - Filter passes content up to 3.3 kHz
// - Settles from zero within 580 ms
// - Results read as 32 bits, top byte zero
// - Every result has a writable signed offset
// - Offset times 128 added before square root
// - Offsets read 32 bits, sign-extended to 28
// - Wiring field 01 selects three-wire delta
// - Delta: phase B voltage results are A-C line
// - Delta: phase B offsets apply to line voltage
// - Nothing computed until run register holds 0x0001
`timescale 1ns/100ps
`default_nettype none

module rmse_engine
  import rmse_pkg::*;
#(
  parameter logic [14:0] CYCLE_CLKS = RMSE_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Sample streams, held valid by the front end
  input  wire rmse_samples_s samples,
  // Register port
  input  wire rmse_reg_req_s reg_req,
  output var  rmse_reg_rsp_s reg_rsp_q,
  // Status
  output var  logic          busy_q,
  output var  logic          done_q,
  output var  logic          delta_mode_q
);

  // ****************************************************************************
  // Arithmetic helpers
  // ****************************************************************************
  function automatic logic [SQW-1:0] rmse_sq(input logic [SW-1:0] m);
    return m * m;
  endfunction

  function automatic logic [SW-1:0] rmse_abs(input logic [SW-1:0] x);
    return x[SW-1] ? SW'(-x) : x;
  endfunction

  function automatic logic [SW-1:0] rmse_sext(input logic [23:0] x);
    return {{(SW-24){x[23]}}, x};
  endfunction

  // ****************************************************************************
  // State
  // ****************************************************************************
  localparam rmse_state_s STATE_RST = '{
    fsm:    ST_IDLE,
    run:    RUN_RST,
    nsel:   NSEL_RST,
    wiring: WIRE_RST,
    default: '0
  };

  rmse_state_s s_q;
  rmse_state_s s_d;

  logic [NCH-1:0][23:0] raw;

  assign raw = samples;

  // ****************************************************************************
  // Next-state logic
  // ****************************************************************************
  always_comb begin
    logic                tick;
    logic [7:0]          oidx;
    logic [SQW-1:0]      sq;
    logic [FW-1:0]       newf;
    logic signed [63:0]  diff;
    logic signed [63:0]  upd;
    logic [27:0]         off28;
    logic signed [53:0]  m;
    logic [SW-1:0]       trial;
    logic [SW-1:0]       rnew;
    logic signed [SW-1:0] sum3;

    tick  = 1'b0;
    oidx  = '0;
    sq    = '0;
    newf  = '0;
    diff  = '0;
    upd   = '0;
    off28 = '0;
    m     = '0;
    trial = '0;
    rnew  = '0;
    sum3  = '0;
    s_d   = s_q;

    s_d.done       = 1'b0;
    s_d.rsp.rvalid = 1'b0;
    s_d.rsp.err    = 1'b0;
    s_d.delta      = (s_q.wiring == WIRE_DELTA);

    // ****************************************************************************
    // Register writes
    // ****************************************************************************
    oidx = reg_req.addr - ADDR_OFFS_BASE;
    if (reg_req.wr_en) begin
      if (reg_req.addr >= ADDR_OFFS_BASE && oidx < 8'(NCH)) begin
        s_d.offs[oidx[4:0]] = reg_req.wdata[23:0];
      end else if (reg_req.addr == ADDR_CONFIG) begin
        s_d.nsel = reg_req.wdata[NSEL_BIT];
      end else if (reg_req.addr == ADDR_ACCUMULATION_MODE_REGISTER) begin
        s_d.wiring = reg_req.wdata[WIRE_HI:WIRE_LO];
      end else if (reg_req.addr == ADDR_RUN) begin
        s_d.run = (reg_req.wdata[15:0] == RUN_START);
      end else if (reg_req.addr >= 8'(NCH)) begin
        // Result registers ignore writes quietly; anything else is unmapped
        s_d.rsp.err = 1'b1;
      end
    end

    // ****************************************************************************
    // Register reads
    // ****************************************************************************
    if (reg_req.rd_en) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = 32'h0;
      if (reg_req.addr < 8'(NCH)) begin
        s_d.rsp.rdata = {8'h00, s_q.res[reg_req.addr[4:0]]};
      end else if (reg_req.addr >= ADDR_OFFS_BASE && oidx < 8'(NCH)) begin
        off28 = {{4{s_q.offs[oidx[4:0]][23]}}, s_q.offs[oidx[4:0]]};
        s_d.rsp.rdata = {4'h0, off28};
      end else if (reg_req.addr == ADDR_CONFIG) begin
        s_d.rsp.rdata[NSEL_BIT] = s_q.nsel;
      end else if (reg_req.addr == ADDR_ACCUMULATION_MODE_REGISTER) begin
        s_d.rsp.rdata[WIRE_HI:WIRE_LO] = s_q.wiring;
      end else if (reg_req.addr == ADDR_RUN) begin
        s_d.rsp.rdata[15:0] = s_q.run ? RUN_START : 16'h0000;
      end else begin
        s_d.rsp.err = 1'b1;
      end
    end

    // ****************************************************************************
    // Computation cycle timer
    // ****************************************************************************
    // Free running while enabled so the cycle rate stays fixed
    if (!s_q.run || s_q.timer == 15'h0000) begin
      s_d.timer = 15'(CYCLE_CLKS - 15'h0001);
    end else begin
      s_d.timer = s_q.timer - 15'h0001;
    end
    tick = s_q.run && (s_q.timer == 15'h0000);

    // ****************************************************************************
    // Sequencer
    // ****************************************************************************
    case (s_q.fsm)
      ST_IDLE: begin
        if (tick) begin
          // All channels latched on the same edge
          for (int i = 0; i < NCH; i++) begin
            s_d.smp[i] = rmse_sext(raw[i]);
          end
          if (s_q.nsel) begin
            sum3 = rmse_sext(samples.cur_a) + rmse_sext(samples.cur_b)
                 + rmse_sext(samples.cur_c);
            s_d.smp[CH_CUR_N] = sum3;
          end
          if (s_q.wiring == WIRE_DELTA) begin
            s_d.smp[CH_VOLT_B]  = rmse_sext(samples.volt_a)
                                - rmse_sext(samples.volt_c);
            s_d.smp[CH_FVOLT_B] = rmse_sext(samples.fvolt_a)
                                - rmse_sext(samples.fvolt_c);
          end
          s_d.chan = 5'h00;
          s_d.busy = 1'b1;
          s_d.fsm  = ST_FILT;
        end
      end

      ST_FILT: begin
        // Full-width square keeps every harmonic in the mean
        sq   = rmse_sq(rmse_abs(s_q.smp[s_q.chan]));
        // One-pole filter: wide enough for 3.3 kHz content, settles in 580 ms
        diff = $signed({2'b00, sq, {FILT_SHIFT{1'b0}}})
             - $signed({2'b00, s_q.filt[s_q.chan]});
        upd  = $signed({2'b00, s_q.filt[s_q.chan]}) + (diff >>> FILT_SHIFT);
        newf = upd[FW-1:0];
        s_d.filt[s_q.chan] = newf;
        off28 = {{4{s_q.offs[s_q.chan][23]}}, s_q.offs[s_q.chan]};
        m = $signed({2'b00, newf[FW-1:FILT_SHIFT]})
          + $signed({{19{off28[27]}}, off28, 7'b0000000});
        if (m[53]) begin
          s_d.rad = '0;
        end else if (m[52]) begin
          s_d.rad = '1;
        end else begin
          s_d.rad = m[SQW-1:0];
        end
        s_d.root = '0;
        s_d.bitn = 5'(SW - 1);
        s_d.fsm  = ST_ROOT;
      end

      ST_ROOT: begin
        // One result bit per clock keeps a single small multiplier
        trial = s_q.root | (SW'(1) << s_q.bitn);
        rnew  = (rmse_sq(trial) <= s_q.rad) ? trial : s_q.root;
        s_d.root = rnew;
        if (s_q.bitn == 5'h00) begin
          if (rnew[SW-1:23] != '0) begin
            s_d.stage[s_q.chan] = RES_SAT;
          end else begin
            s_d.stage[s_q.chan] = {1'b0, rnew[22:0]};
          end
          if (s_q.chan == CH_LAST) begin
            s_d.fsm = ST_COMMIT;
          end else begin
            s_d.chan = s_q.chan + 5'h01;
            s_d.fsm  = ST_FILT;
          end
        end else begin
          s_d.bitn = s_q.bitn - 5'h01;
        end
      end

      ST_COMMIT: begin
        // Whole set moves in one edge, so no read mixes two cycles
        s_d.res  = s_q.stage;
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.fsm  = ST_IDLE;
      end

      default: begin
        s_d.fsm  = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // ****************************************************************************
  // State register
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  assign reg_rsp_q    = s_q.rsp;
  assign busy_q       = s_q.busy;
  assign done_q       = s_q.done;
  assign delta_mode_q = s_q.delta;

endmodule

`default_nettype wire

/* File: bench/rmse_engine_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Register port and sequencing checks
// ****************************************
module rmse_engine_asserts
  import rmse_pkg::*;
#(
  parameter logic [14:0] CYCLE_CLKS = RMSE_CYCLE_CLKS
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire rmse_samples_s samples,
  input wire rmse_reg_req_s reg_req,
  input wire rmse_reg_rsp_s reg_rsp_q,
  input wire logic          busy_q,
  input wire logic          done_q,
  input wire logic          delta_mode_q
);
  logic       hole;
  logic       req;
  logic [9:0] span_q;
  // Counts edges of one busy span; a long delay would be unrolled by the tools
  always_ff @(posedge clk) begin
    if (rst || !busy_q) begin
      span_q <= 10'h000;
    end else begin
      span_q <= span_q + 10'h001;
    end
  end
  assign req = reg_req.rd_en || reg_req.wr_en;
  assign hole = (reg_req.addr > 8'h11 && reg_req.addr < 8'h20) ||
                (reg_req.addr > 8'h31 && reg_req.addr < 8'h40) || reg_req.addr > 8'h42;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (reg_req.rd_en |=> reg_rsp_q.rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rsp_q.rvalid |-> $past(reg_req.rd_en))
    else $error("read answer without read");
  a_err_cause: assert property (reg_rsp_q.err |-> $past(req) && $past(hole))
    else $error("error without unmapped access");
  a_hole_err: assert property (req && hole |=> reg_rsp_q.err)
    else $error("unmapped access not flagged");
  a_result_fmt: assert property (reg_rsp_q.rvalid && $past(reg_req.addr) < 8'h12 |->
    reg_rsp_q.rdata[31:24] == 8'h00)
    else $error("result top byte not zero");
  a_offset_fmt: assert property (reg_rsp_q.rvalid && $past(reg_req.addr) >= 8'h20 &&
    $past(reg_req.addr) <= 8'h31 |->
    reg_rsp_q.rdata[31:24] == {4'h0, {4{reg_rsp_q.rdata[23]}}})
    else $error("offset not sign extended");
  a_busy_span: assert property (done_q |-> span_q == 10'h1e7)
    else $error("sequence length wrong");
  a_busy_limit: assert property (busy_q |-> span_q < 10'h1e7)
    else $error("sequence runs too long");
  a_busy_done: assert property ($fell(busy_q) |-> done_q)
    else $error("busy ended without commit");
  a_done_end: assert property (done_q |-> !busy_q && $past(busy_q))
    else $error("done without busy end");
  a_done_gap: assert property (done_q |=> !done_q [*8])
    else $error("done repeats");
  a_delta_follow: assert property (reg_req.wr_en && reg_req.addr == ADDR_ACCUMULATION_MODE_REGISTER |->
    ##2 delta_mode_q == ($past(reg_req.wdata[WIRE_HI:WIRE_LO], 2) == WIRE_DELTA))
    else $error("delta mode wrong");
endmodule
bind rmse_engine rmse_engine_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.clk(clk), .rst(rst),
  .samples(samples), .reg_req(reg_req), .reg_rsp_q(reg_rsp_q), .busy_q(busy_q),
  .done_q(done_q), .delta_mode_q(delta_mode_q));
`default_nettype wire

/* File: bench/rmse_engine_test.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module rmse_engine_test
  import rmse_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
  } rmse_row_s;
  logic          clk;
  logic          rst;
  rmse_samples_s samples;
  rmse_reg_req_s reg_req;
  rmse_reg_rsp_s reg_rsp_q;
  logic          busy_q;
  logic          done_q;
  logic          delta_mode_q;
  logic [31:0]   rd_v;
  logic [31:0]   v;
  logic          rd_e;
  int            err_total = 0;
  int            checked = 0;
  int            dones = 0;
  int            n;
  // Write then read back; the last two rows are unmapped
  rmse_row_s rows[12] = '{
    '{8'h00, 32'h00000123, 32'h0, 1'b0}, '{8'h11, 32'hffffffff, 32'h0, 1'b0},
    '{8'h20, 32'h00000002, 32'h00000002, 1'b0}, '{8'h31, 32'hab800000, 32'h0f800000, 1'b0},
    '{8'h25, 32'h00fffffe, 32'h0ffffffe, 1'b0}, '{8'h40, 32'hffffffff, 32'h00004000, 1'b0},
    '{8'h41, 32'h000000ff, 32'h00000030, 1'b0}, '{8'h42, 32'h00010001, 32'h00000001, 1'b0},
    '{8'h42, 32'h00000002, 32'h0, 1'b0}, '{8'h2f, 32'h007fffff, 32'h007fffff, 1'b0},
    '{8'h12, 32'h00000001, 32'h0, 1'b1}, '{8'h50, 32'h00000001, 32'h0, 1'b1}};

  // Short cycle keeps the run small; must exceed the 487-cycle sequence
  rmse_engine #(.CYCLE_CLKS(15'd600)) dut (.clk(clk), .rst(rst), .samples(samples),
    .reg_req(reg_req), .reg_rsp_q(reg_rsp_q), .busy_q(busy_q), .done_q(done_q),
    .delta_mode_q(delta_mode_q));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (done_q === 1'b1) dones <= dones + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request, then an idle edge so strobes never toggle twice in a step
  task automatic req(input logic wr, input logic [7:0] a, input logic [31:0] w);
    @(negedge clk);
    reg_req = '{wr, !wr, a, w};
    @(negedge clk);
    reg_req = '0;
    rd_v = reg_rsp_q.rdata;
    rd_e = reg_rsp_q.err;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    req(1'b0, a, 32'h0);
    check(rd_v, exp);
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    while (done_q !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    check({31'h0, done_q}, 32'h1);
    @(negedge clk);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #300000;
    err_total++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    samples = '0;
    reg_req = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 18; i++) begin
      rdchk(8'(i), 32'h0);
      rdchk(8'(i) + 8'h20, 32'h0);
    end
    rdchk(8'h40, 32'h0);
    rdchk(8'h42, 32'h0);
    $display("test reset values done");
    foreach (rows[i]) begin
      req(1'b1, rows[i].a, rows[i].w);
      req(1'b0, rows[i].a, 32'h0);
      check(rd_v, rows[i].r);
      check({31'h0, rd_e}, {31'h0, rows[i].e});
    end
    $display("test register rows done");
    // Zero input: each result is the root of offset times 128, or 0 where the offset is negative
    do_reset();
    rdchk(8'h25, 32'h0);
    rdchk(8'h40, 32'h0);
    req(1'b1, 8'h20, 32'h00000002);
    req(1'b1, 8'h21, 32'h00000008);
    req(1'b1, 8'h22, 32'h00fffffb);
    req(1'b1, 8'h24, 32'h00000200);
    repeat (1300) @(negedge clk);
    check(32'(dones), 32'h0);
    req(1'b1, 8'h42, 32'h00000001);
    wait_done();
    check({31'h0, busy_q}, 32'h0);
    rdchk(8'h00, 32'd16);
    rdchk(8'h01, 32'd32);
    rdchk(8'h02, 32'h0);
    rdchk(8'h04, 32'd256);
    req(1'b1, 8'h42, 32'h0);
    n = dones;
    repeat (1300) @(negedge clk);
    check(32'(dones), 32'(n));
    $display("test offset roots done");
    // Phase sum cancels, line voltage A-C is zero in delta
    do_reset();
    samples.cur_a = 24'h080000;
    samples.cur_b = 24'hf80000;
    samples.cur_n = 24'h100000;
    samples.volt_a = 24'h100000;
    samples.volt_b = 24'h040000;
    samples.volt_c = 24'h100000;
    samples.fvolt_a = 24'h0c0000;
    samples.fvolt_b = 24'h040000;
    samples.fvolt_c = 24'h0c0000;
    req(1'b1, 8'h40, 32'h00004000);
    req(1'b1, 8'h41, 32'h00000010);
    req(1'b1, 8'h25, 32'h00000002);
    check({31'h0, delta_mode_q}, 32'h1);
    req(1'b1, 8'h42, 32'h00000001);
    wait_done();
    rdchk(8'h03, 32'h0);
    rdchk(8'h05, 32'd16);
    rdchk(8'h10, 32'h0);
    req(1'b0, 8'h00, 32'h0);
    v = rd_v;
    // First filter step leaves x*x/1024 as mean square, so the root is x/32
    check(v, 32'd16384);
    rdchk(8'h01, v);
    req(1'b0, 8'h04, 32'h0);
    check({31'h0, rd_v > v}, 32'h1);
    req(1'b1, 8'h40, 32'h0);
    wait_done();
    wait_done();
    req(1'b0, 8'h03, 32'h0);
    check({31'h0, rd_v != 32'h0}, 32'h1);
    $display("test neutral and delta done");
    close_out();
  end
endmodule
`default_nettype wire
